// ### core/flash_boot_mode_control.sv
`timescale 1ns/1ps
module flash_boot_mode_control
  import boot_ctl_pkg::*;
(
  // Reset, watchdog and mode pins
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wdt_reset,
  input wire logic test_pin_high,
  input wire logic programming_voltage_pin,
  // Serial line and byte handshake
  input wire logic rxd,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  // Array sequencer handshakes
  input wire logic blank_done,
  input wire logic blank_all_ones,
  input wire logic erase_done,
  input wire logic erase_fail,
  input wire logic load_done,
  // CPU writes to the control bits, and its interrupt
  input wire logic [3:0] flash_ctrl_wr,
  input wire logic flash_ctrl_we,
  input wire logic irq_req,
  // Operating mode status
  output logic boot_mode,
  output logic user_mode,
  output logic port_test_mode,
  // Serial port state
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic receiver_enable_bit,
  output logic transmitter_enable_bit,
  output logic [BAUD_W-1:0] baud_divisor_reg,
  output logic txd_dir_out,
  output logic txd_data,
  // Array control and hand-over
  output logic blank_start,
  output logic erase_all_start,
  output logic [FLASH_BLOCKS-1:0] erase_blocks,
  output logic cpu_regs_undef,
  output logic branch_valid,
  output logic [15:0] branch_addr,
  output logic halted,
  // Flash mode and interrupt gate
  output logic [3:0] flash_control_reg,
  output flash_mode_type flash_mode,
  output logic flash_read_ok,
  output logic irq_out
);
  boot_state_type st_reg, st_next;
  logic latch_reg, latch_next;
  logic sampled_reg, sampled_next;
  logic [7:0] wait_reg, wait_next;
  logic [BAUD_W-1:0] baud_next;
  logic rx_on_next, tx_on_next;
  logic txd_dir_next, txd_data_next;
  logic tx_valid_next;
  logic [7:0] tx_data_next;
  logic branch_next, undef_next;
  logic [3:0] fc_next;
  logic meas_en;
  logic [BAUD_W-1:0] low_count;
  logic low_done;
  logic boot_live;

  flash_if fl();

  // Low-period timer only counts while the loader is measuring
  low_period_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .enable(meas_en),
    .rxd(rxd),
    .low_count(low_count),
    .done(low_done)
  );

  // Pure decode of the control bits, no state of its own
  flash_mode_decode u_decode (
    .fl(fl)
  );

  assign fl.ctrl_bits = flash_control_reg;
  assign fl.prog_voltage = programming_voltage_pin;
  assign flash_mode = fl.mode;
  assign flash_read_ok = fl.read_ok;
  assign irq_out = irq_req && !fl.busy;

  // boot state needs test pin voltage
  assign boot_live = latch_reg && test_pin_high;
  assign boot_mode = boot_live;
  assign user_mode = !boot_live && programming_voltage_pin;
  // ports follow test pin in reset
  assign port_test_mode = rst_n ? boot_live : test_pin_high;

  // Level strobes taken straight from the state register
  assign meas_en = (st_reg == ST_MEASURE);
  assign blank_start = (st_reg == ST_BLANK_CHECK);
  assign erase_all_start = (st_reg == ST_ERASE);
  assign halted = (st_reg == ST_HALT);

  // A partial erase would leave old code beside the new download
  // every block selected
  for (genvar b = 0; b < FLASH_BLOCKS; b++) begin : g_block
    assign erase_blocks[b] = (st_reg == ST_ERASE);
  end

  // Hand-over target is fixed at the start of the download area
  assign branch_addr = RAM_START;

  // Latch decision: the first clock after release samples the pins,
  // since an async reset may only load a constant
  always_comb begin
    latch_next = latch_reg;
    sampled_next = 1'b1;
    if (!sampled_reg) begin
      latch_next = test_pin_high && programming_voltage_pin;
    end else if (!test_pin_high) begin
      latch_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
      sampled_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      sampled_reg <= sampled_next;
    end
  end

  // Loader sequence; watchdog restarts it but never touches the latch
  always_comb begin
    st_next = st_reg;
    wait_next = wait_reg;
    baud_next = baud_divisor_reg;
    rx_on_next = receiver_enable_bit;
    tx_on_next = transmitter_enable_bit;
    txd_dir_next = txd_dir_out;
    txd_data_next = txd_data;
    tx_valid_next = 1'b0;
    tx_data_next = tx_data;
    branch_next = 1'b0;
    undef_next = cpu_regs_undef;
    fc_next = flash_control_reg;
    if (flash_ctrl_we) fc_next = flash_ctrl_wr;
    case (st_reg)
      ST_IDLE: begin
        // Leave once the boot latch has been sampled and is set
        wait_next = '0;
        if (sampled_reg && latch_reg) st_next = ST_WAIT_READY;
      end
      ST_WAIT_READY: begin
        wait_next = wait_reg + 1'b1;
        if (wait_reg == READY_CYCLES - 8'd1) st_next = ST_MEASURE;
      end
      ST_MEASURE: begin
        // Low run length in clocks becomes the divisor
        if (low_done) begin
          baud_next = low_count;
          rx_on_next = 1'b1;
          tx_on_next = 1'b1;
          st_next = ST_SEND_DONE;
        end
      end
      ST_SEND_DONE: begin
        if (tx_ready) begin
          tx_valid_next = 1'b1;
          tx_data_next = BYTE_ADJ_DONE;
          st_next = ST_WAIT_SYNC;
        end
      end
      ST_WAIT_SYNC: begin
        if (rx_valid && rx_data == BYTE_SYNC) st_next = ST_BLANK_CHECK;
      end
      ST_BLANK_CHECK: begin
        if (blank_done) begin
          st_next = blank_all_ones ? ST_LOAD : ST_ERASE;
        end
      end
      ST_ERASE: begin
        // The sequencer reports exactly one outcome per erase
        // failure goes to the error byte
        if (erase_fail) st_next = ST_ERR;
        else if (erase_done) st_next = ST_LOAD;
      end
      ST_ERR: begin
        if (tx_ready) begin
          tx_valid_next = 1'b1;
          tx_data_next = BYTE_ERASE_ERR;
          st_next = ST_HALT;
        end
      end
      ST_HALT: begin
        // Nothing more is sent, so the host sees a single error byte
        // stay halted until reset or loss of the test voltage
        st_next = ST_HALT;
      end
      ST_LOAD: begin
        // Length bytes and echo are handled outside; only the end shows
        if (load_done) st_next = ST_HANDOVER;
      end
      ST_HANDOVER: begin
        // Divisor untouched so user code keeps the adjusted rate
        // stop serial, keep divisor
        rx_on_next = 1'b0;
        tx_on_next = 1'b0;
        txd_dir_next = 1'b1;
        txd_data_next = 1'b1;
        undef_next = 1'b1;
        branch_next = 1'b1;
        st_next = ST_USER;
      end
      ST_USER: begin
        // User code runs; the loader stays parked until a reset or loss of the test voltage
        st_next = ST_USER;
      end
      default: begin
        // Unused codes fall back to idle rather than lock up
        st_next = ST_IDLE;
      end
    endcase
    // Losing the test voltage abandons the loader
    if (sampled_reg && !boot_live && st_reg != ST_IDLE) st_next = ST_IDLE;
    if (wdt_reset && boot_live) begin
      st_next = ST_WAIT_READY;
      wait_next = '0;
      rx_on_next = 1'b0;
      tx_on_next = 1'b0;
      fc_next = FC_RESET;
    end
  end

  // Loader registers; reset values are the power-on state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      wait_reg <= '0;
      baud_divisor_reg <= '0;
      receiver_enable_bit <= 1'b0;
      transmitter_enable_bit <= 1'b0;
      txd_dir_out <= 1'b0;
      txd_data <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= '0;
      branch_valid <= 1'b0;
      cpu_regs_undef <= 1'b0;
      flash_control_reg <= FC_RESET;
    end else begin
      st_reg <= st_next;
      wait_reg <= wait_next;
      baud_divisor_reg <= baud_next;
      receiver_enable_bit <= rx_on_next;
      transmitter_enable_bit <= tx_on_next;
      txd_dir_out <= txd_dir_next;
      txd_data <= txd_data_next;
      tx_valid <= tx_valid_next;
      tx_data <= tx_data_next;
      branch_valid <= branch_next;
      cpu_regs_undef <= undef_next;
      flash_control_reg <= fc_next;
    end
  end
endmodule

// ### inc/boot_ctl_pkg.sv
package boot_ctl_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned READY_STATES = 100;
  localparam logic [7:0] READY_CYCLES = 8'(READY_STATES);
  localparam int unsigned EXIT_CLOCKS = 10;
  // Serial bytes, download start address and length limit
  localparam logic [7:0] BYTE_BLANK = 8'hff;
  localparam logic [7:0] BYTE_ADJ_DONE = 8'h00;
  localparam logic [7:0] BYTE_SYNC = 8'h55;
  localparam logic [7:0] BYTE_ERASE_ERR = 8'hff;
  localparam logic [7:0] BYTE_ACK = 8'haa;
  localparam logic [15:0] RAM_START = 16'hfbe0;
  localparam logic [15:0] MAX_LOAD = 16'h038e;
  // Flash control bit positions, reset value, block count and divisor width
  localparam int unsigned FC_PROG = 0;
  localparam int unsigned FC_ERASE = 1;
  localparam int unsigned FC_WRITE_CHECK = 2;
  localparam int unsigned FC_WIPE_CHECK = 3;
  localparam logic [3:0] FC_RESET = 4'h0;
  localparam int unsigned FLASH_BLOCKS = 8;
  localparam int unsigned BAUD_W = 16;

  typedef enum logic [2:0] {
    FM_READ = 3'b000,
    FM_PROGRAM = 3'b001,
    FM_ERASE = 3'b010,
    FM_PROG_VERIFY = 3'b011,
    FM_ERASE_VERIFY = 3'b100,
    FM_PREWRITE_VERIFY = 3'b101
  } flash_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WAIT_READY = 4'b0001,
    ST_MEASURE = 4'b0010,
    ST_SEND_DONE = 4'b0011,
    ST_WAIT_SYNC = 4'b0100,
    ST_BLANK_CHECK = 4'b0101,
    ST_ERASE = 4'b0110,
    ST_ERR = 4'b0111,
    ST_HALT = 4'b1000,
    ST_LOAD = 4'b1001,
    ST_HANDOVER = 4'b1010,
    ST_USER = 4'b1011
  } boot_state_type;
endpackage

// ### inc/flash_if.sv
`timescale 1ns/1ps
// Flash control bits and status shared by the decode module
interface flash_if;
  import boot_ctl_pkg::*;
  logic [3:0] ctrl_bits;
  logic prog_voltage;
  flash_mode_type mode;
  logic busy;
  logic read_ok;
  modport ctl (output ctrl_bits, output prog_voltage, input mode,
               input busy, input read_ok);
  modport dec (input ctrl_bits, input prog_voltage, output mode,
               output busy, output read_ok);
endinterface

// ### core/flash_mode_decode.sv
`timescale 1ns/1ps
module flash_mode_decode
  import boot_ctl_pkg::*;
(
  flash_if.dec fl
);
  // Decode four control bits into one of the six operating modes
  // six modes decoded
  always_comb begin
    fl.mode = FM_READ;
    if (fl.prog_voltage) begin
      case (fl.ctrl_bits)
        4'h1: fl.mode = FM_PROGRAM;
        4'h2: fl.mode = FM_ERASE;
        4'h4: fl.mode = FM_PROG_VERIFY;
        4'h8: fl.mode = FM_ERASE_VERIFY;
        4'hc: fl.mode = FM_PREWRITE_VERIFY;
        default: fl.mode = FM_READ;
      endcase
    end
  end
  // Array is busy and unreadable during program or erase
  assign fl.busy = (fl.mode == FM_PROGRAM) || (fl.mode == FM_ERASE);
  assign fl.read_ok = !fl.busy;
endmodule

// ### core/low_period_timer.sv
`timescale 1ns/1ps
module low_period_timer
  import boot_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rxd,
  output logic [BAUD_W-1:0] low_count,
  output logic done
);
  logic [BAUD_W-1:0] cnt_reg, cnt_next;
  logic [BAUD_W-1:0] res_reg, res_next;
  logic rxd_d_reg, rxd_d_next;
  logic done_reg, done_next;

  // Count the low run; result taken at the rising edge of rxd
  always_comb begin
    cnt_next = cnt_reg;
    res_next = res_reg;
    done_next = 1'b0;
    rxd_d_next = rxd;
    if (!enable) begin
      cnt_next = '0;
    end else if (!rxd) begin
      if (cnt_reg != '1) cnt_next = cnt_reg + 1'b1;
    end else if (!rxd_d_reg && cnt_reg != '0) begin
      res_next = cnt_reg;
      done_next = 1'b1;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      res_reg <= '0;
      rxd_d_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      res_reg <= res_next;
      rxd_d_reg <= rxd_d_next;
      done_reg <= done_next;
    end
  end

  assign low_count = res_reg;
  assign done = done_reg;
endmodule

// ### dv/flash_boot_mode_control_props.sv
`timescale 1ns/1ps
module flash_boot_mode_control_props
  import boot_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wdt_reset,
  input wire logic test_pin_high,
  input wire logic programming_voltage_pin,
  input wire logic irq_req,
  input wire logic boot_mode,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic receiver_enable_bit,
  input wire logic transmitter_enable_bit,
  input wire logic [BAUD_W-1:0] baud_divisor_reg,
  input wire logic txd_dir_out,
  input wire logic txd_data,
  input wire logic erase_all_start,
  input wire logic [FLASH_BLOCKS-1:0] erase_blocks,
  input wire logic cpu_regs_undef,
  input wire logic branch_valid,
  input wire logic [15:0] branch_addr,
  input wire logic halted,
  input wire logic [3:0] flash_control_reg,
  input wire flash_mode_type flash_mode,
  input wire logic flash_read_ok,
  input wire logic irq_out
);
  logic [7:0] up_reg;
  logic [7:0] up_next;
  // Cycles since reset release, saturating
  always_comb begin
    up_next = (up_reg == 8'hff) ? up_reg : up_reg + 8'h01;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_reg <= 8'h00;
    else up_reg <= up_next;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_wait: assert property (
    up_reg < 8'h64 |=> $stable(baud_divisor_reg)) else $error("early baud");
  a_erase_all: assert property (
    erase_all_start |-> &erase_blocks) else $error("partial erase");
  a_irq_blocked: assert property (
    flash_mode inside {FM_PROGRAM, FM_ERASE} |-> !irq_out && !flash_read_ok)
    else $error("irq or read while busy");
  a_irq_pass: assert property (
    irq_req && flash_mode == FM_READ |-> irq_out) else $error("irq lost");
  a_handover_pins: assert property (
    branch_valid |-> !receiver_enable_bit && !transmitter_enable_bit &&
    txd_dir_out && txd_data && cpu_regs_undef && branch_addr == RAM_START)
    else $error("bad handover state");
  a_baud_kept: assert property (
    branch_valid |-> $stable(baud_divisor_reg)) else $error("baud lost");
  a_boot_needs_test: assert property (
    !test_pin_high |-> !boot_mode) else $error("boot without test pin");
  a_wdt_keeps: assert property (
    wdt_reset && boot_mode |=> boot_mode && flash_control_reg == FC_RESET)
    else $error("watchdog lost boot");
  a_mode_novolt: assert property (
    !programming_voltage_pin |-> flash_mode == FM_READ) else $error("no vpp");
  a_err_halts: assert property (
    tx_valid && tx_data == BYTE_ERASE_ERR |-> ##[0:2] halted)
    else $error("no halt after error");
  cover property (branch_valid);
  cover property (erase_all_start);
  cover property (halted);
endmodule
bind flash_boot_mode_control flash_boot_mode_control_props u_props (.*);

// ### dv/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] low_len,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [9:0] t_reg;
  logic [3:0] r_reg;
  logic [9:0] len;
  assign len = {2'b00, low_len};
  // Host timeline from reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_reg <= 10'h000;
      r_reg <= 4'h0;
      rxd <= 1'b1;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      tx_ready <= 1'b0;
    end else begin
      t_reg <= (t_reg == 10'h3ff) ? t_reg : t_reg + 10'h001;
      // First low falls in the ready wait, so it must be ignored
      rxd <= !((t_reg >= 10'h01e && t_reg < 10'h01e + len) ||
        (t_reg >= 10'h096 && t_reg < 10'h096 + len));
      tx_ready <= |t_reg[1:0];
      r_reg <= (tx_valid && tx_data == 8'h00) ? 4'h1 : r_reg + {3'h0, |r_reg};
      // stray byte, then sync; noise in between
      rx_valid <= (r_reg == 4'h3 || r_reg == 4'h6);
      rx_data <= (r_reg == 4'h3 || r_reg == 4'h6) ?
        {7'h2a, r_reg == 4'h6} : ~rx_data;
    end
  end
endmodule

// ### dv/flash_boot_mode_control_test.sv
`timescale 1ns/1ps
module flash_boot_mode_control_test;
  import boot_ctl_pkg::*;
  logic clk, rst_n, wdt_reset, test_pin_high, programming_voltage_pin;
  logic rxd, rx_valid, tx_ready, blank_done, blank_all_ones, erase_done;
  logic erase_fail, load_done, flash_ctrl_we, irq_req, boot_mode, user_mode;
  logic port_test_mode, tx_valid, receiver_enable_bit, transmitter_enable_bit;
  logic txd_dir_out, txd_data, blank_start, erase_all_start, cpu_regs_undef;
  logic branch_valid, halted, flash_read_ok, irq_out;
  logic [7:0] rx_data, tx_data, low_len;
  logic [3:0] flash_ctrl_wr, flash_control_reg;
  logic [BAUD_W-1:0] baud_divisor_reg;
  logic [FLASH_BLOCKS-1:0] erase_blocks;
  logic [15:0] branch_addr;
  flash_mode_type flash_mode;
  int n_mismatch, num_checks;
  flash_boot_mode_control u_flash_boot_mode_control (.*);
  serial_host_model u_serial_host_model (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic step();
    @(posedge clk);
    #5;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Mode expected from control bits and programming voltage
  function automatic flash_mode_type want_mode(logic [3:0] c, logic v);
    if (!v) return FM_READ;
    case (c)
      4'h1: return FM_PROGRAM;
      4'h2: return FM_ERASE;
      4'h4: return FM_PROG_VERIFY;
      4'h8: return FM_ERASE_VERIFY;
      4'hc: return FM_PREWRITE_VERIFY;
      default: return FM_READ;
    endcase
  endfunction
  function automatic logic pick(int k);
    if (k == 0) return blank_start;
    if (k == 1) return branch_valid;
    return tx_valid;
  endfunction
  // Bounded wait; running out ends the run as a failure
  task automatic wait_for(int k);
    for (int n = 0; pick(k) !== 1'b1; n++) begin
      if (n > 3000) begin
        check("wait", 16'h0, 16'h1);
        close_out();
      end
      step();
    end
  endtask
  task automatic boot_run(int kind);
    logic [3:0] c;
    flash_mode_type m;
    logic idle_want;
    low_len = 8'(20 + $urandom % 40);
    rst_n = 1'b0;
    // boot voltage dropped ten clocks into a later reset
    repeat (kind == 0 ? 4 : 10) step();
    test_pin_high = 1'b0;
    step();
    check("port_test_mode", 16'(port_test_mode), 16'h0);
    test_pin_high = 1'b1;
    step();
    check("port_test_mode", 16'(port_test_mode), 16'h1);
    rst_n = 1'b1;
    step();
    step();
    check("boot_mode", 16'(boot_mode), 16'h1);
    check("user_mode", 16'(user_mode), 16'h0);
    // mode pins held while the loader runs
    wait_for(0);
    check("baud", baud_divisor_reg, 16'(low_len));
    blank_all_ones = (kind == 0);
    blank_done = 1'b1;
    step();
    blank_done = 1'b0;
    if (kind != 0) begin
      step();
      check("erase", {erase_all_start, erase_blocks}, 16'h1ff);
      erase_done = (kind == 1);
      erase_fail = (kind == 2);
      step();
      {erase_done, erase_fail} = 2'b00;
    end
    if (kind == 2) begin
      wait_for(2);
      check("err byte", 16'(tx_data), 16'(BYTE_ERASE_ERR));
      load_done = 1'b1;
      step();
      load_done = 1'b0;
      repeat (3) begin
        check("halt", {halted, branch_valid}, 16'h2);
        step();
      end
    end else begin
      load_done = 1'b1;
      step();
      load_done = 1'b0;
      wait_for(1);
      check("handover", {receiver_enable_bit, transmitter_enable_bit,
        txd_dir_out, txd_data, cpu_regs_undef}, 16'h07);
      check("addr", branch_addr, RAM_START);
      check("baud", baud_divisor_reg, 16'(low_len));
      irq_req = 1'b1;
      // voltage changed only beside control writes
      for (int i = 0; i < 8; i++) begin
        c = (i < 7) ? 4'(32'h0c842100 >> (4 * i)) : 4'($urandom);
        programming_voltage_pin = (i != 7);
        flash_ctrl_wr = c;
        flash_ctrl_we = 1'b1;
        step();
        flash_ctrl_we = 1'b0;
        step();
        m = want_mode(c, programming_voltage_pin);
        idle_want = !(m inside {FM_PROGRAM, FM_ERASE});
        check("mode", 16'(flash_mode), 16'(m));
        check("irq", 16'(irq_out), 16'(idle_want));
        check("read", 16'(flash_read_ok), 16'(idle_want));
      end
      irq_req = 1'b0;
      programming_voltage_pin = 1'b1;
      // watchdog acts while voltage is on
      wdt_reset = 1'b1;
      step();
      wdt_reset = 1'b0;
      step();
      check("wdt", {boot_mode, flash_control_reg}, 16'h10);
      test_pin_high = 1'b0;
      step();
      check("boot_mode", 16'(boot_mode), 16'h0);
      check("user_mode", 16'(user_mode), 16'h1);
      {test_pin_high, programming_voltage_pin} = 2'b11;
    end
    $display("run %0d done", kind);
  endtask
  initial begin
    {wdt_reset, blank_done, blank_all_ones, erase_done} = '0;
    {erase_fail, load_done, flash_ctrl_we, irq_req} = '0;
    flash_ctrl_wr = '0;
    {test_pin_high, programming_voltage_pin} = 2'b11;
    void'($urandom(35247));
    for (int k = 0; k < 3; k++) boot_run(k);
    close_out();
  end
endmodule
